// ===== ldf_pkg.sv
// Purpose: Shared constants and types for the line diagnostic filters
// Assumes: 100 MHz clock, APB register access, 32-bit data
// Notes:   Byte addresses; per-channel blocks sit at 0x40 and 0x60
package ldf_pkg;
    // Rates and dividers
    localparam int CLK_HZ      = 100_000_000;
    localparam int MON_RATE_HZ = 800;
    localparam int AUD_RATE_HZ = 8000;
    localparam int MON_DIV     = CLK_HZ / MON_RATE_HZ;
    localparam int AUD_DIV     = CLK_HZ / AUD_RATE_HZ;

    // Audio filter format, Q2.22 coefficients
    localparam int          NSTG      = 3;
    localparam int          NCOEF     = 15;
    localparam int          COEF_FRAC = 22;
    localparam int          K_FRAC    = 16;
    localparam logic [24:0] COEF_ONE  = 25'h0400000;

    // Global register byte addresses
    localparam logic [7:0] ADDR_TONE_ROUTE = 8'h00;
    localparam logic [7:0] ADDR_RING_CFG   = 8'h04;
    localparam logic [1:0] CH_REGION       = 2'h1;
    localparam logic [1:0] COEF_REGION     = 2'h2;
    localparam logic [5:0] COEF_BASE_IDX   = 6'h20;
    localparam logic [7:0] ADDR_WIN_LEN    = 8'hbc;
    localparam logic [7:0] ADDR_POW_COEFF  = 8'hc0;
    localparam logic [7:0] ADDR_APEAK      = 8'hc4;
    localparam logic [7:0] ADDR_APOWER     = 8'hc8;

    // Per-channel word offsets
    localparam logic [2:0] OFS_DIAGNOSTICS_CONFIG_CFG = 3'h0;
    localparam logic [2:0] OFS_DC_COEFF = 3'h1;
    localparam logic [2:0] OFS_AC_COEFF = 3'h2;
    localparam logic [2:0] OFS_LPEAK    = 3'h3;
    localparam logic [2:0] OFS_DC_RES   = 3'h4;
    localparam logic [2:0] OFS_AC_RES   = 3'h5;
    localparam logic [2:0] OFS_VOLT     = 3'h6;
    localparam logic [2:0] OFS_CURR     = 3'h7;

    // Reset values
    localparam logic [15:0] DIAGNOSTICS_CONFIG_K_RST = 16'h0100;
    localparam logic [15:0] WIN_RST    = 16'h0320;
    localparam logic [15:0] POW_K_RST  = 16'h0100;

    typedef enum logic [2:0] {
        SRC_TIP_V, SRC_RING_V, SRC_LOOP_V, SRC_LONG_V,
        SRC_LOOP_I, SRC_LONG_I, SRC_EXT_V, SRC_EXT_I
    } ldf_src_t;

    // Config word: bit 0 enable, bits 3:1 source
    typedef struct packed {
        ldf_src_t sel;
        logic     en;
    } ldf_cfg_t;

    typedef struct packed {
        logic signed [7:0] tipV;
        logic signed [7:0] ringV;
        logic signed [7:0] tipI;
        logic signed [7:0] ringI;
        logic signed [7:0] extV;
        logic signed [7:0] extI;
    } ldf_mon_t;
endpackage : ldf_pkg

// ===== ldf_line_diagnostic_filters.sv
// Purpose: Line diagnostic filters and transmit audio diagnostic filter
// Assumes: Samples and tone come from logic on this clock
// Notes:   Slower rates are one-cycle tick enables on the single clock
// Contract
// - Monitor samples processed per channel at 800 Hz.
// - Loop and longitudinal values computed and kept readable.
// - Peak, dc, ac filters run only while diagnostic enable set.
// - Each channel has its own filter set and config.
// - Off-hook or ring trip clears diagnostic enable and stops processing.
// - Source code 0..7 selects the diagnostic input.
// - Peak detector holds largest unsigned magnitude.
// - Dc single-pole low-pass with host coefficient, readable result.
// - Ac path rectifies then single-pole low-pass with host coefficient.
// - Enable rise or source change zeroes peak and flushes filters.
// - Host writes zero to peak result to restart tracking.
// - Line filters only run while voice processing inactive.
// - Transmit audio sixth-order IIR at 8 kHz, three biquads.
// - Five host coefficients per stage, 25 bits each.
// - Feedback terms added with positive sign.
// - b0 one and others zero gives pass-through stage.
// - Audio peak over programmable window, updated at window end.
// - Audio power averaged by single-pole IIR, readable.
// - Test tone routed to transmit or receive path.
// - Diagnostic ringing balanced or unbalanced by config bit.
`timescale 1ns/1ps
`default_nettype none
module ldf_line_diagnostic_filters #(
    parameter int MON_DIV = ldf_pkg::MON_DIV,
    parameter int AUD_DIV = ldf_pkg::AUD_DIV
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    // APB slave
    input  wire logic [7:0]              paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Monitor converter samples and line status
    input  wire ldf_pkg::ldf_mon_t [1:0] monIn,
    input  wire logic [1:0]              offHook,
    input  wire logic [1:0]              ringTrip,
    input  wire logic [1:0]              voiceActive,
    // Audio streams
    input  wire logic [15:0]             txIn,
    input  wire logic [15:0]             rxIn,
    input  wire logic [15:0]             toneIn,
    input  wire logic [15:0]             ringWave,
    output logic      [15:0]             txOut,
    output logic      [15:0]             rxOut,
    output logic      [15:0]             ringTip,
    output logic      [15:0]             ringRing,
    output logic      [1:0]              diagEnabled
);
    typedef struct packed {
        logic [5:0]               sync1;
        logic [5:0]               sync2;
        logic [16:0]              monCnt;
        logic [13:0]              audCnt;
        ldf_pkg::ldf_cfg_t [1:0]  cfgW;
        ldf_pkg::ldf_cfg_t [1:0]  cfgA;
        logic [1:0][15:0]         dcKW;
        logic [1:0][15:0]         dcKA;
        logic [1:0][15:0]         acKW;
        logic [1:0][15:0]         acKA;
        logic [1:0][15:0]         loopV;
        logic [1:0][15:0]         longV;
        logic [1:0][15:0]         loopI;
        logic [1:0][15:0]         longI;
        logic [1:0][15:0]         peak;
        logic [1:0][23:0]         dc;
        logic [1:0][23:0]         ac;
        logic [14:0][24:0]        coefW;
        logic [14:0][24:0]        coefA;
        logic [2:0][15:0]         x1;
        logic [2:0][15:0]         x2;
        logic [2:0][15:0]         y1;
        logic [2:0][15:0]         y2;
        logic [15:0]              winW;
        logic [15:0]              winA;
        logic [15:0]              winCnt;
        logic [15:0]              winMax;
        logic [15:0]              aPeak;
        logic [15:0]              powKW;
        logic [15:0]              powKA;
        logic [31:0]              power;
        logic                     toneRx;
        logic                     unbal;
        logic [15:0]              txOut;
        logic [15:0]              rxOut;
        logic [15:0]              ringTip;
        logic [15:0]              ringRing;
        logic [31:0]              rdata;
        logic                     err;
    } ldf_state_t;

    function automatic ldf_state_t ldfStateRst();
        ldf_state_t r;
        r = '0;
        for (int i = 0; i < ldf_pkg::NSTG; i++) begin
            r.coefW[i*5] = ldf_pkg::COEF_ONE;
            r.coefA[i*5] = ldf_pkg::COEF_ONE;
        end
        r.dcKW  = {2{ldf_pkg::DIAGNOSTICS_CONFIG_K_RST}};
        r.dcKA  = {2{ldf_pkg::DIAGNOSTICS_CONFIG_K_RST}};
        r.acKW  = {2{ldf_pkg::DIAGNOSTICS_CONFIG_K_RST}};
        r.acKA  = {2{ldf_pkg::DIAGNOSTICS_CONFIG_K_RST}};
        r.winW  = ldf_pkg::WIN_RST;
        r.winA  = ldf_pkg::WIN_RST;
        r.powKW = ldf_pkg::POW_K_RST;
        r.powKA = ldf_pkg::POW_K_RST;
        return r;
    endfunction : ldfStateRst

    localparam ldf_state_t ST_RST = ldfStateRst();

    function automatic logic [15:0] sat16(input logic signed [43:0] v);
        if (v > 44'sd32767) begin
            return 16'h7fff;
        end
        if (v < -44'sd32768) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction : sat16

    logic [1:0]         rstPipe;
    logic               rstSyncN;
    ldf_state_t         s_q;
    ldf_state_t         s_d;
    logic               tickMon;
    logic               tickAud;
    logic               wrEn;
    logic               rdSet;
    logic               chHit;
    logic               coefHit;
    logic [5:0]         coefIdx;
    logic [31:0]        rd;
    logic               rdErr;
    logic [1:0]         hookEv;
    logic [1:0]         voice;
    logic [1:0]         wrPeak;
    logic [1:0]         flush;
    logic [1:0]         run;
    logic signed [15:0] tv [2];
    logic signed [15:0] rv [2];
    logic signed [15:0] ti [2];
    logic signed [15:0] ri [2];
    logic signed [15:0] selV [2];
    logic [15:0]        absSel [2];
    logic [15:0]        peakBase [2];
    logic signed [23:0] dcBase [2];
    logic signed [23:0] acBase [2];
    logic signed [41:0] dcStep [2];
    logic signed [41:0] acStep [2];
    logic signed [15:0] audIn;
    logic signed [15:0] xin [3];
    logic signed [15:0] yv [3];
    logic signed [43:0] acc [3];
    logic [15:0]        absY;
    logic [15:0]        curMax;
    logic               winEnd;
    logic [31:0]        pw;
    logic signed [49:0] powStep;

    // Reset release through two flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe[1];

    assign pready      = psel & penable;
    assign prdata      = s_q.rdata;
    assign pslverr     = s_q.err & psel & penable;
    assign txOut       = s_q.txOut;
    assign rxOut       = s_q.rxOut;
    assign ringTip     = s_q.ringTip;
    assign ringRing    = s_q.ringRing;
    assign diagEnabled = {s_q.cfgW[1].en, s_q.cfgW[0].en};

    always_comb begin
        s_d     = s_q;
        tickMon = (s_q.monCnt == 17'h0);
        tickAud = (s_q.audCnt == 14'h0);
        s_d.monCnt = tickMon ? 17'(MON_DIV - 1) : s_q.monCnt - 17'h1;
        s_d.audCnt = tickAud ? 14'(AUD_DIV - 1) : s_q.audCnt - 14'h1;
        s_d.sync1  = {voiceActive, ringTrip, offHook};
        s_d.sync2  = s_q.sync1;
        hookEv     = s_q.sync2[1:0] | s_q.sync2[3:2];
        voice      = s_q.sync2[5:4];

        // Bus decode, read data latched in the setup cycle
        wrEn    = psel & penable & pwrite;
        rdSet   = psel & ~penable;
        chHit   = (paddr[7:6] == ldf_pkg::CH_REGION) && (paddr[1:0] == 2'h0);
        coefIdx = paddr[7:2] - ldf_pkg::COEF_BASE_IDX;
        coefHit = (paddr[7:6] == ldf_pkg::COEF_REGION) && (paddr[1:0] == 2'h0)
                  && (coefIdx < 6'(ldf_pkg::NCOEF));
        rd      = 32'h0;
        rdErr   = 1'b0;
        if (chHit) begin
            case (paddr[4:2])
                ldf_pkg::OFS_DIAGNOSTICS_CONFIG_CFG: rd = {28'h0, s_q.cfgW[paddr[5]]};
                ldf_pkg::OFS_DC_COEFF: rd = {16'h0, s_q.dcKW[paddr[5]]};
                ldf_pkg::OFS_AC_COEFF: rd = {16'h0, s_q.acKW[paddr[5]]};
                ldf_pkg::OFS_LPEAK:    rd = {16'h0, s_q.peak[paddr[5]]};
                ldf_pkg::OFS_DC_RES:   rd = {8'h0, s_q.dc[paddr[5]]};
                ldf_pkg::OFS_AC_RES:   rd = {8'h0, s_q.ac[paddr[5]]};
                ldf_pkg::OFS_VOLT:     rd = {s_q.longV[paddr[5]], s_q.loopV[paddr[5]]};
                default:               rd = {s_q.longI[paddr[5]], s_q.loopI[paddr[5]]};
            endcase
        end else if (coefHit) begin
            rd = {7'h0, s_q.coefW[coefIdx[3:0]]};
        end else begin
            case (paddr)
                ldf_pkg::ADDR_TONE_ROUTE: rd = {31'h0, s_q.toneRx};
                ldf_pkg::ADDR_RING_CFG:   rd = {31'h0, s_q.unbal};
                ldf_pkg::ADDR_WIN_LEN:    rd = {16'h0, s_q.winW};
                ldf_pkg::ADDR_POW_COEFF:  rd = {16'h0, s_q.powKW};
                ldf_pkg::ADDR_APEAK:      rd = {16'h0, s_q.aPeak};
                ldf_pkg::ADDR_APOWER:     rd = s_q.power;
                default:                  rdErr = 1'b1;
            endcase
        end
        if (rdSet) begin
            s_d.rdata = pwrite ? 32'h0 : rd;
            s_d.err   = rdErr;
        end

        // Host writes land in staging copies; tone route, ring config and peak writes act directly
        wrPeak = 2'h0;
        if (wrEn && chHit) begin
            case (paddr[4:2])
                ldf_pkg::OFS_DIAGNOSTICS_CONFIG_CFG: s_d.cfgW[paddr[5]] = pwdata[3:0];
                ldf_pkg::OFS_DC_COEFF: s_d.dcKW[paddr[5]] = pwdata[15:0];
                ldf_pkg::OFS_AC_COEFF: s_d.acKW[paddr[5]] = pwdata[15:0];
                ldf_pkg::OFS_LPEAK:    wrPeak[paddr[5]]   = 1'b1;
                default: ;
            endcase
        end else if (wrEn && coefHit) begin
            s_d.coefW[coefIdx[3:0]] = pwdata[24:0];
        end else if (wrEn) begin
            case (paddr)
                ldf_pkg::ADDR_TONE_ROUTE: s_d.toneRx = pwdata[0];
                ldf_pkg::ADDR_RING_CFG:   s_d.unbal  = pwdata[0];
                ldf_pkg::ADDR_WIN_LEN:    s_d.winW   = pwdata[15:0];
                ldf_pkg::ADDR_POW_COEFF:  s_d.powKW  = pwdata[15:0];
                default: ;
            endcase
        end

        // Line diagnostics, one set per channel
        for (int c = 0; c < 2; c++) begin
            tv[c] = 16'(monIn[c].tipV);
            rv[c] = 16'(monIn[c].ringV);
            ti[c] = 16'(monIn[c].tipI);
            ri[c] = 16'(monIn[c].ringI);
            case (s_d.cfgW[c].sel)
                ldf_pkg::SRC_TIP_V:  selV[c] = tv[c];
                ldf_pkg::SRC_RING_V: selV[c] = rv[c];
                ldf_pkg::SRC_LOOP_V: selV[c] = tv[c] - rv[c];
                ldf_pkg::SRC_LONG_V: selV[c] = (tv[c] + rv[c]) >>> 1;
                ldf_pkg::SRC_LOOP_I: selV[c] = ti[c] - ri[c];
                ldf_pkg::SRC_LONG_I: selV[c] = (ti[c] + ri[c]) >>> 1;
                ldf_pkg::SRC_EXT_V:  selV[c] = 16'(monIn[c].extV);
                default:             selV[c] = 16'(monIn[c].extI);
            endcase
            absSel[c] = selV[c][15] ? 16'(-selV[c]) : selV[c];
            // Enable rise or source change restarts peak, dc and ac
            flush[c] = tickMon && s_d.cfgW[c].en && !hookEv[c]
                       && (!s_q.cfgA[c].en || s_d.cfgW[c].sel != s_q.cfgA[c].sel);
            run[c]   = tickMon && s_d.cfgW[c].en && !hookEv[c] && !voice[c];
            peakBase[c] = wrPeak[c] ? pwdata[15:0] : (flush[c] ? 16'h0 : s_q.peak[c]);
            dcBase[c]   = flush[c] ? 24'sh0 : $signed(s_q.dc[c]);
            acBase[c]   = flush[c] ? 24'sh0 : $signed(s_q.ac[c]);
            dcStep[c]   = ($signed({selV[c], 8'h0}) - dcBase[c])
                          * $signed({1'b0, s_q.dcKA[c]});
            acStep[c]   = ($signed({absSel[c], 8'h0}) - acBase[c])
                          * $signed({1'b0, s_q.acKA[c]});
            s_d.peak[c] = peakBase[c];
            s_d.dc[c]   = dcBase[c];
            s_d.ac[c]   = acBase[c];
            if (run[c]) begin
                if (absSel[c] > peakBase[c]) begin
                    s_d.peak[c] = absSel[c];
                end
                s_d.dc[c] = dcBase[c] + 24'(dcStep[c] >>> ldf_pkg::K_FRAC);
                s_d.ac[c] = acBase[c] + 24'(acStep[c] >>> ldf_pkg::K_FRAC);
            end
            if (tickMon) begin
                s_d.loopV[c] = tv[c] - rv[c];
                s_d.longV[c] = (tv[c] + rv[c]) >>> 1;
                s_d.loopI[c] = ti[c] - ri[c];
                s_d.longI[c] = (ti[c] + ri[c]) >>> 1;
                s_d.cfgA[c]  = s_d.cfgW[c];
                s_d.dcKA[c]  = s_q.dcKW[c];
                s_d.acKA[c]  = s_q.acKW[c];
            end
            // Hardware clear beats a host write in the same cycle
            if (hookEv[c]) begin
                s_d.cfgW[c].en = 1'b0;
                s_d.cfgA[c].en = 1'b0;
            end
        end

        // Tone injection and diagnostic ringing
        audIn = s_q.toneRx ? $signed(txIn)
                : $signed(sat16(44'($signed(txIn)) + 44'($signed(toneIn))));
        s_d.txOut = audIn;
        s_d.rxOut = s_q.toneRx ? sat16(44'($signed(rxIn)) + 44'($signed(toneIn))) : rxIn;
        s_d.ringTip  = s_q.unbal ? ringWave : 16'($signed(ringWave) >>> 1);
        s_d.ringRing = s_q.unbal ? 16'h0 : 16'(-($signed(ringWave) >>> 1));

        // Three cascaded biquads, positive feedback sign
        for (int s = 0; s < ldf_pkg::NSTG; s++) begin
            xin[s] = (s == 0) ? audIn : yv[(s == 0) ? 0 : s - 1];
            acc[s] = $signed(s_q.coefA[s*5])   * xin[s]
                   + $signed(s_q.coefA[s*5+1]) * $signed(s_q.x1[s])
                   + $signed(s_q.coefA[s*5+2]) * $signed(s_q.x2[s])
                   + $signed(s_q.coefA[s*5+3]) * $signed(s_q.y1[s])
                   + $signed(s_q.coefA[s*5+4]) * $signed(s_q.y2[s]);
            yv[s]  = sat16(acc[s] >>> ldf_pkg::COEF_FRAC);
            if (tickAud) begin
                s_d.x1[s] = xin[s];
                s_d.x2[s] = s_q.x1[s];
                s_d.y1[s] = yv[s];
                s_d.y2[s] = s_q.y1[s];
            end
        end

        // Windowed peak and averaged power
        absY    = yv[2][15] ? 16'(-yv[2]) : yv[2];
        curMax  = (absY > s_q.winMax) ? absY : s_q.winMax;
        winEnd  = tickAud && ({16'h0, s_q.winCnt} + 32'h1 >= {16'h0, s_q.winA});
        pw      = 32'(yv[2] * yv[2]);
        powStep = $signed({1'b0, pw} - {1'b0, s_q.power}) * $signed({1'b0, s_q.powKA});
        if (tickAud) begin
            s_d.winCnt = winEnd ? 16'h0 : s_q.winCnt + 16'h1;
            s_d.winMax = winEnd ? 16'h0 : curMax;
            s_d.power  = s_q.power + 32'(powStep >>> ldf_pkg::K_FRAC);
            s_d.coefA  = s_q.coefW;
            s_d.winA   = s_q.winW;
            s_d.powKA  = s_q.powKW;
        end
        if (winEnd) begin
            s_d.aPeak = curMax;
        end
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSyncN);

    chk_mon_tick_rate: assert property (tickMon |=> s_q.monCnt == 17'(MON_DIV - 1))
        else $error("monitor divider not reloaded");
    chk_loop_value: assert property (tickMon |=> $signed(s_q.loopV[0])
        == $signed($past(monIn[0].tipV)) - $signed($past(monIn[0].ringV)))
        else $error("loop voltage wrong");
    chk_filter_gate: assert property (!(run[1] || flush[1]) |=> $stable(s_q.dc[1]))
        else $error("dc filter moved while idle");
    chk_hook_clear: assert property ((hookEv[0] && s_q.cfgW[0].en)
        |=> !s_q.cfgW[0].en && !s_q.cfgA[0].en ##1 !run[0])
        else $error("enable not cleared on hook event");
    chk_peak_holds: assert property (run[0] && !wrPeak[0]
        |=> s_q.peak[0] >= $past(absSel[0]))
        else $error("peak below sample");
    chk_flush_zero: assert property (flush[0] && !run[0] && !wrPeak[0]
        |=> s_q.peak[0] == 16'h0 && s_q.dc[0] == 24'h0)
        else $error("flush did not clear");
    chk_peak_write: assert property (wrPeak[1] && !run[1]
        |=> s_q.peak[1] == $past(pwdata[15:0]))
        else $error("peak write lost");
    chk_voice_block: assert property (voice[0] |-> !run[0])
        else $error("filters ran during voice");
    chk_pass_stage: assert property ((tickAud && s_q.coefA[0] == ldf_pkg::COEF_ONE
        && s_q.coefA[4:1] == '0) |=> s_q.y1[0] == s_q.x1[0])
        else $error("pass-through stage altered data");
    chk_window_end: assert property (!$stable(s_q.aPeak) |-> $past(winEnd))
        else $error("audio peak changed mid window");
    chk_ring_balance: assert property (!$past(s_q.unbal)
        |-> s_q.ringRing == 16'(-$signed(s_q.ringTip)))
        else $error("balanced ringing not symmetric");
    chk_coef_boundary: assert property (!tickAud |=> $stable(s_q.coefA))
        else $error("coefficients changed off boundary");

    cov_hook_clear: cover property (run[0] ##[1:300] hookEv[0]);
    cov_window_end: cover property (winEnd ##1 s_q.aPeak != 16'h0);
    cov_peak_restart: cover property (wrPeak[0] ##[1:300] run[0]);
endmodule : ldf_line_diagnostic_filters
`default_nettype wire

// ===== ldf_host_model.sv
// Purpose: Host processor model on the APB port
// Assumes: Slave may add up to 62 wait states
// Notes:   Released bus shows inverted last address and write data
`timescale 1ns/1ps
`default_nettype none
module ldf_host_model (
    // Clock
    input  wire logic        clock,
    // APB master side
    output logic [7:0]       paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
    end

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e, output logic hung);
        int n;
        @(posedge clock);
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        psel    <= 1'b1;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 64);
        r = prdata;
        e = pslverr;
        hung = (n >= 64);
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer
endmodule : ldf_host_model
`default_nettype wire

// ===== test_line_diagnostic_filters.sv
// Purpose: Register-level test of the line diagnostic filters
// Assumes: Short dividers 40 and 8
// Notes:   Sequences of host reads and writes
`timescale 1ns/1ps
`default_nettype none
module test_line_diagnostic_filters;
    localparam int M = 88;
    logic                    clock, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]              paddr;
    logic [31:0]             pwdata, prdata, rdata;
    ldf_pkg::ldf_mon_t [1:0] monIn;
    logic [1:0]              offHook, ringTrip, voiceActive, diagEnabled;
    logic [15:0]             txIn, rxIn, toneIn, ringWave, txOut, rxOut, ringTip, ringRing;
    logic                    rerr, hung;
    logic [7:0]              expPk [8] = '{8'h14, 8'h06, 8'h1a, 8'h07, 8'h06, 8'h06, 8'h07, 8'h05};
    int                      errors, checks_done;

    ldf_host_model host (.clock, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr);
    ldf_line_diagnostic_filters #(.MON_DIV(40), .AUD_DIV(8)) dut (.clock, .reset_n, .paddr,
        .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .monIn, .offHook,
        .ringTrip, .voiceActive, .txIn, .rxIn, .toneIn, .ringWave, .txOut, .rxOut, .ringTip,
        .ringRing, .diagEnabled);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task test_done;
        $display("Checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        host.xfer(w, a, d, rdata, rerr, hung);
        if (hung !== 1'b0) begin
            errors++;
            test_done();
        end
    endtask : xf

    task wr(input logic [7:0] a, input logic [31:0] d);
        xf(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hffffffff);
        xf(1'b0, a, 32'h0);
        check(rdata & m, x);
    endtask : rd

    initial begin
        repeat (100000) @(posedge clock);
        errors++;
        test_done();
    end

    initial begin
        {offHook, ringTrip, voiceActive, txIn, rxIn, toneIn, ringWave} = '0;
        monIn[0] = {8'hec, 8'h06, 8'h09, 8'h03, 8'hf9, 8'h05};
        monIn[1] = {8'h32, 40'h0};
        reset_n = 1'b0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(8'h44, 32'h100);
        rd(8'h80, 32'h0400000);
        rd(8'hbc, 32'h320);
        rd(8'hcc, 32'h0);
        check({31'h0, rerr}, 32'h1);
        $display("Test reset values done");
        for (int s = 0; s < 8; s++) begin
            wr(8'h40, {28'h0, s[2:0], 1'b1});
            repeat (M) @(posedge clock);
            rd(8'h4c, {24'h0, expPk[s]});
        end
        rd(8'h58, 32'he6, 32'hff);
        check({30'h0, diagEnabled}, 32'h1);
        rd(8'h6c, 32'h0);
        wr(8'h6c, 32'h55);
        rd(8'h6c, 32'h55);
        monIn[0].extI <= 8'h03;
        wr(8'h4c, 32'h0);
        repeat (M) @(posedge clock);
        rd(8'h4c, 32'h3);
        monIn[0].extI <= 8'h09;
        repeat (M) @(posedge clock);
        rd(8'h4c, 32'h9);
        voiceActive <= 2'b01;
        repeat (4) @(posedge clock);
        wr(8'h40, 32'hd);
        wr(8'h4c, 32'h0);
        repeat (M) @(posedge clock);
        rd(8'h4c, 32'h0);
        voiceActive <= 2'b00;
        wr(8'h40, 32'hc);
        wr(8'h44, 32'hffff);
        wr(8'h48, 32'hffff);
        repeat (M) @(posedge clock);
        wr(8'h4c, 32'h7f);
        wr(8'h40, 32'hd);
        repeat (M) @(posedge clock);
        rd(8'h4c, 32'h7);
        rd(8'h50, 32'hfff900);
        rd(8'h54, 32'h6ff);
        offHook <= 2'b01;
        repeat (6) @(posedge clock);
        check({30'h0, diagEnabled}, 32'h0);
        rd(8'h40, 32'h0, 32'h1);
        offHook <= 2'b00;
        $display("Test line diagnostics done");
        ringWave <= 16'h0100;
        repeat (4) @(posedge clock);
        check({ringTip, ringRing}, 32'h0080ff80);
        wr(8'h04, 32'h1);
        repeat (4) @(posedge clock);
        check({ringTip, ringRing}, 32'h01000000);
        txIn <= 16'h1234;
        rxIn <= 16'h0100;
        toneIn <= 16'h0010;
        repeat (4) @(posedge clock);
        check({txOut, rxOut}, 32'h12440100);
        wr(8'h00, 32'h1);
        repeat (4) @(posedge clock);
        check({txOut, rxOut}, 32'h12340110);
        $display("Test ringing and tone done");
        wr(8'hbc, 32'h1);
        repeat (80) @(posedge clock);
        rd(8'hc4, 32'h1234);
        txIn <= 16'h0100;
        wr(8'h8c, 32'h0200000);
        repeat (400) @(posedge clock);
        rd(8'hc4, 32'h1ff);
        wr(8'h8c, 32'h0400000);
        wr(8'hc0, 32'hffff);
        repeat (1400) @(posedge clock);
        rd(8'hc4, 32'h7fff);
        rd(8'hc8, 32'h3fff0000);
        $display("Test audio filter done");
        test_done();
    end
endmodule : test_line_diagnostic_filters
`default_nettype wire
